// file: hdl/pcei_consts.svh
// constants for the phy control and event interrupt block
`ifndef PCEI_CONSTS_SVH
`define PCEI_CONSTS_SVH
// register offsets on the register port
`define PCEI_ADDR_CTRL    5'h11
`define PCEI_ADDR_EVT     5'h12
`define PCEI_ADDR_ISTAT   5'h1a
`define PCEI_ADDR_IMASK   5'h1b
// reset values
`define PCEI_RST_CTRL     16'h0108
`define PCEI_RST_EVT      8'h00
`define PCEI_RST_IRQ      3'h0
// writable bits of the special control register
`define PCEI_CTRL_RW_MASK 16'hff1f
// power save field codes
`define PCEI_PS_NORMAL    2'h0
`define PCEI_PS_SLEEP     2'h2
// loopback fifo depth codes and nibble counts
`define PCEI_FD_4         2'h0
`define PCEI_FD_5         2'h1
`define PCEI_FD_6         2'h2
`define PCEI_FD_8         2'h3
`define PCEI_NIB_4        4'h4
`define PCEI_NIB_5        4'h5
`define PCEI_NIB_6        4'h6
`define PCEI_NIB_8        4'h8
// own interrupt status bit positions
`define PCEI_IRQ_SLEEP    0
`define PCEI_IRQ_WAKE     1
`define PCEI_IRQ_PWRDN    2
// link pulse period in active sleep
`define PCEI_NLP_MS       1400
`define PCEI_CLK_KHZ      40000
`define PCEI_NLP_CYC      (`PCEI_NLP_MS * `PCEI_CLK_KHZ)
`define PCEI_CNT_W        26
`endif

// file: hdl/pcei_pkg.sv
// types for the phy control and event interrupt block
package pcei_pkg;
   typedef struct packed {
      logic       clk_dis;
      logic       ps_en;
      logic [1:0] ps_mode;
      logic       scr_byp;
      logic       rsv10;
      logic [1:0] fifo_dep;
      logic [2:0] rsv;
      logic       col_fd;
      logic       int_pol;
      logic       test_int;
      logic       int_en;
      logic       int_oe;
   } pcei_ctrl_t;

   // status levels from the core, order matches event bits 15 down to 8
   typedef struct packed {
      logic lq;
      logic energy;
      logic link;
      logic speed;
      logic duplex;
      logic an_done;
      logic fcs_half;
      logic rxe_half;
   } pcei_line_t;

   typedef enum logic [0:0] {
      PCEI_RUN   = 1'b0,
      PCEI_SLEEP = 1'b1
   } pcei_ps_t;
endpackage : pcei_pkg

// file: hdl/pcei_top.sv
// control register, event interrupt register and interrupt pin logic
//
// Overview of operation
// R01 - clock disable bit 15 only stops clocks while in standard power down
// R02 - bit 14 enables power save; when clear device stays in normal operation
// R03 - power save field: 0 normal, 1 reserved, 2 active sleep
// R04 - active sleep sends a link pulse every 1.4 s, wakes on partner
// R05 - bit 11 set bypasses the 100 Mbps scrambler
// R06 - fifo depth field: 4, 5, 6 or 8 nibbles, default 5
// R07 - loopback fifo absorbs rx/tx clock rate difference; software sizes it
// R08 - collision only in half duplex unless bit 4 allows full duplex too
// R09 - bit 3 polarity: 0 idle low active high, 1 idle high active low
// R10 - test interrupt bit keeps the interrupt asserted while set
// R11 - bit 1 master enable gates all event interrupts
// R12 - bit 0 makes the shared pin an interrupt output, else power down input
// R13 - bit 15 link quality change while up, bit 14 energy change; clear on read
// R14 - bits 13, 12, 11 set on link, speed, duplex change; pending until read
// R15 - bit 10 set on auto-negotiation complete, pending until read
// R16 - bits 9 and 8 set when error counters pass half range
// R17 - enable bits 7 to 0 read/write, reset 0, match status bits 15 to 8
// R18 - interrupt asserts when enabled event pending or test set; idles after
`timescale 1ns/100ps
`include "pcei_consts.svh"

module pcei_top #(
   parameter int NLP_CYC = `PCEI_NLP_CYC,
   parameter int CNT_W   = `PCEI_CNT_W
) (
   // clock and reset
   input  wire logic                CLK,
   input  wire logic                RST,
   // register port
   input  wire logic [4:0]          ADDR,
   input  wire logic [15:0]         WDATA,
   input  wire logic                WR,
   input  wire logic                RD,
   output logic      [15:0]         RDATA,
   // core status
   input  wire pcei_pkg::pcei_line_t LINE,
   input  wire logic                IEEE_PWRDN,
   input  wire logic                COL_RAW,
   // shared interrupt or power down pin
   input  wire logic                INT_PIN_I,
   output logic                     INT_PIN_O,
   output logic                     INT_PIN_OE,
   // core controls
   output logic                     CLK_STOP,
   output logic                     SLEEP,
   output logic                     NLP_PULSE,
   output logic                     SCR_BYPASS,
   output logic      [3:0]          FIFO_NIBBLES,
   output logic                     COL_OUT,
   output logic                     PIN_PWRDN,
   // system interrupt
   output logic                     IRQ
);

   function automatic logic [3:0] fifo_nib(input logic [1:0] code);
      logic [3:0] n;
      n = `PCEI_NIB_5;
      unique case (code)
         `PCEI_FD_4: n = `PCEI_NIB_4;
         `PCEI_FD_5: n = `PCEI_NIB_5;
         `PCEI_FD_6: n = `PCEI_NIB_6;
         `PCEI_FD_8: n = `PCEI_NIB_8;
      endcase
      return n;
   endfunction : fifo_nib

   function automatic logic sticky(input logic q, input logic clr, input logic set);
      return (q & ~clr) | set;
   endfunction : sticky

   // register state
   pcei_pkg::pcei_ctrl_t ctrl;
   pcei_pkg::pcei_ctrl_t next_ctrl;
   logic [7:0]           evt_st;
   logic [7:0]           next_evt_st;
   logic [7:0]           evt_en;
   logic [7:0]           next_evt_en;
   logic [2:0]           istat;
   logic [2:0]           next_istat;
   logic [2:0]           imask;
   logic [2:0]           next_imask;
   // input history and pin synchroniser
   pcei_pkg::pcei_line_t prev;
   logic                 pin_s1;
   logic                 pin_s2;
   // power save state
   pcei_pkg::pcei_ps_t   ps;
   pcei_pkg::pcei_ps_t   next_ps;
   logic [CNT_W-1:0]     cnt;
   logic [CNT_W-1:0]     next_cnt;
   // output values
   logic [15:0]          next_rdata;
   logic                 next_int_o;
   logic                 next_pwrdn;
   logic                 next_nlp;
   logic                 next_col;
   // events
   logic [7:0]           evt_set;
   logic [2:0]           irq_set;
   logic                 int_act;
   logic                 rd_evt;

   localparam logic [CNT_W-1:0] NLP_LAST = CNT_W'(NLP_CYC - 1);

   // event detection from the core levels
   always_comb begin
      evt_set    = 8'h00;
      evt_set[7] = (LINE.lq ^ prev.lq) & LINE.link;             // [R13]
      evt_set[6] = LINE.energy ^ prev.energy;                   // [R13]
      evt_set[5] = LINE.link ^ prev.link;                       // [R14]
      evt_set[4] = LINE.speed ^ prev.speed;                     // [R14]
      evt_set[3] = LINE.duplex ^ prev.duplex;                   // [R14]
      evt_set[2] = LINE.an_done & ~prev.an_done;                // [R15]
      evt_set[1] = LINE.fcs_half & ~prev.fcs_half;              // [R16]
      evt_set[0] = LINE.rxe_half & ~prev.rxe_half;              // [R16]
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         prev   <= '0;
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         prev   <= LINE;
         pin_s1 <= INT_PIN_I;
         pin_s2 <= pin_s1;
      end
   end

   // register file
   assign rd_evt = RD && (ADDR == `PCEI_ADDR_EVT);

   always_comb begin
      next_ctrl   = ctrl;
      next_evt_en = evt_en;
      next_imask  = imask;
      next_istat  = istat;
      for (int i = 0; i < 8; i++) begin
         next_evt_st[i] = sticky(evt_st[i], rd_evt, evt_set[i]); // [R13] [R14]
      end
      if (WR) begin
         unique case (ADDR)
            `PCEI_ADDR_CTRL: next_ctrl = pcei_pkg::pcei_ctrl_t'(WDATA & `PCEI_CTRL_RW_MASK);
            `PCEI_ADDR_EVT: next_evt_en = WDATA[7:0];            // [R17]
            `PCEI_ADDR_IMASK: next_imask = WDATA[2:0];
            default: next_ctrl = ctrl;
         endcase
      end
      for (int i = 0; i < 3; i++) begin
         next_istat[i] = sticky(istat[i], WR && (ADDR == `PCEI_ADDR_ISTAT) && WDATA[i], irq_set[i]);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl   <= pcei_pkg::pcei_ctrl_t'(`PCEI_RST_CTRL);   // [R06] [R09]
         evt_st <= `PCEI_RST_EVT;
         evt_en <= `PCEI_RST_EVT;                             // [R17]
         istat  <= `PCEI_RST_IRQ;
         imask  <= `PCEI_RST_IRQ;
      end else begin
         ctrl   <= next_ctrl;
         evt_st <= next_evt_st;
         evt_en <= next_evt_en;
         istat  <= next_istat;
         imask  <= next_imask;
      end
   end

   // power save state machine
   always_comb begin
      next_ps  = ps;
      next_cnt = cnt;
      irq_set  = 3'h0;
      unique case (ps)
         pcei_pkg::PCEI_RUN: begin
            next_cnt = '0;
            if (ctrl.ps_en && ctrl.ps_mode == `PCEI_PS_SLEEP && !LINE.energy) begin // [R02] [R03]
               next_ps                 = pcei_pkg::PCEI_SLEEP;
               irq_set[`PCEI_IRQ_SLEEP] = 1'b1;
            end
         end
         pcei_pkg::PCEI_SLEEP: begin
            next_cnt = (cnt == NLP_LAST) ? '0 : cnt + 1'b1;     // [R04]
            if (!ctrl.ps_en || ctrl.ps_mode != `PCEI_PS_SLEEP) begin // [R02] [R03]
               next_ps = pcei_pkg::PCEI_RUN;
            end else if (LINE.energy) begin
               next_ps                 = pcei_pkg::PCEI_RUN;  // [R04]
               irq_set[`PCEI_IRQ_WAKE] = 1'b1;
            end
         end
      endcase
      next_pwrdn = !ctrl.int_oe && !pin_s2;                     // [R12]
      irq_set[`PCEI_IRQ_PWRDN] = next_pwrdn && !PIN_PWRDN;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ps  <= pcei_pkg::PCEI_RUN;
         cnt <= '0;
      end else begin
         ps  <= next_ps;
         cnt <= next_cnt;
      end
   end

   // outputs and read data
   always_comb begin
      int_act    = (ctrl.int_en && |(evt_st & evt_en)) || ctrl.test_int; // [R10] [R11] [R18]
      next_int_o = ctrl.int_pol ? !int_act : int_act;           // [R09]
      next_nlp   = (ps == pcei_pkg::PCEI_SLEEP) && (cnt == NLP_LAST); // [R04]
      next_col   = COL_RAW && (!LINE.duplex || ctrl.col_fd);    // [R08]
      next_rdata = 16'h0000;
      if (RD) begin
         unique case (ADDR)
            `PCEI_ADDR_CTRL: next_rdata = ctrl;
            `PCEI_ADDR_EVT: next_rdata = {evt_st, evt_en};
            `PCEI_ADDR_ISTAT: next_rdata = {13'h0000, istat};
            `PCEI_ADDR_IMASK: next_rdata = {13'h0000, imask};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA        <= 16'h0000;
         INT_PIN_O    <= 1'b1;
         INT_PIN_OE   <= 1'b0;
         CLK_STOP     <= 1'b0;
         SLEEP        <= 1'b0;
         NLP_PULSE    <= 1'b0;
         SCR_BYPASS   <= 1'b0;
         FIFO_NIBBLES <= `PCEI_NIB_5;
         COL_OUT      <= 1'b0;
         PIN_PWRDN    <= 1'b0;
         IRQ          <= 1'b0;
      end else begin
         RDATA        <= next_rdata;
         INT_PIN_O    <= next_int_o;
         INT_PIN_OE   <= ctrl.int_oe;                           // [R12]
         CLK_STOP     <= ctrl.clk_dis && IEEE_PWRDN;            // [R01]
         SLEEP        <= (next_ps == pcei_pkg::PCEI_SLEEP);
         NLP_PULSE    <= next_nlp;
         SCR_BYPASS   <= ctrl.scr_byp;                          // [R05]
         FIFO_NIBBLES <= fifo_nib(ctrl.fifo_dep);               // [R06] [R07]
         COL_OUT      <= next_col;
         PIN_PWRDN    <= next_pwrdn;
         IRQ          <= |(next_istat & next_imask);
      end
   end

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_clk_stop_gate: assert property (!IEEE_PWRDN |=> !CLK_STOP) // [R01]
      else $error("clocks stopped outside power down");
   a_sleep_enable: assert property (!ctrl.ps_en |=> !SLEEP) // [R02]
      else $error("sleep while power save disabled");
   a_sleep_mode: assert property (ctrl.ps_mode != `PCEI_PS_SLEEP |=> !SLEEP) // [R03]
      else $error("sleep with other mode selected");
   a_auto_wake: assert property (SLEEP && LINE.energy |=> !SLEEP) // [R04]
      else $error("no wake on partner energy");
   a_nlp_in_sleep: assert property (NLP_PULSE |-> $past(ps == pcei_pkg::PCEI_SLEEP)) // [R04]
      else $error("link pulse outside sleep");
   a_scr_write: assert property (WR && ADDR == `PCEI_ADDR_CTRL |=> ##1 SCR_BYPASS == $past(WDATA[11], 2)) // [R05]
      else $error("scrambler bypass not following write");
   a_fifo_eight: assert property (ctrl.fifo_dep == `PCEI_FD_8 |=> FIFO_NIBBLES == `PCEI_NIB_8) // [R06]
      else $error("fifo depth code 3 not 8 nibbles");
   a_col_half: assert property (COL_OUT |-> $past(COL_RAW && (!LINE.duplex || ctrl.col_fd))) // [R08]
      else $error("collision in full duplex without enable");
   a_test_int: assert property (ctrl.test_int && $stable(ctrl.int_pol) |=> INT_PIN_O != $past(ctrl.int_pol)) // [R10]
      else $error("test interrupt not asserted");
   a_master_off: assert property (!ctrl.int_en && !ctrl.test_int |=> INT_PIN_O == $past(ctrl.int_pol)) // [R11]
      else $error("interrupt without master enable");
   a_pin_role: assert property (WR && ADDR == `PCEI_ADDR_CTRL |=> ##1 INT_PIN_OE == $past(WDATA[0], 2)) // [R12]
      else $error("pin direction not following bit 0");
   a_read_clear: assert property (rd_evt && evt_set == 8'h00 |=> evt_st == 8'h00) // [R13]
      else $error("event status not cleared by read");
   a_set_pending: assert property (|evt_set |=> (evt_st & $past(evt_set)) == $past(evt_set)) // [R14]
      else $error("event lost");
   a_irq_event: assert property (ctrl.int_en && |(evt_st & evt_en) && $stable(ctrl.int_pol)
                                 |=> INT_PIN_O != $past(ctrl.int_pol)) // [R18]
      else $error("enabled event not driving interrupt");

endmodule : pcei_top

// file: verif/pcei_core_model.sv
// behavioural core and host side: status levels, power-down state, pin drive
`timescale 1ns/100ps
module pcei_core_model (
   // clock
   input  wire logic            clk,
   // core levels
   output pcei_pkg::pcei_line_t line,
   output logic                 pwrdn,
   output logic                 col,
   // host drive on the shared pin, low requests power down
   output logic                 host_pin
);
   initial begin
      line = '0;
      pwrdn = 1'b0;
      col = 1'b0;
      host_pin = 1'b1;
   end

   // all levels change together just after a rising edge
   task automatic drive(input logic [7:0] l, input logic p, input logic c, input logic h);
      @(posedge clk);
      line <= l;
      pwrdn <= p;
      col <= c;
      host_pin <= h;
   endtask : drive
endmodule : pcei_core_model

// file: verif/tb.sv
// self-checking bench for the control and event interrupt block
`timescale 1ns/100ps
module tb;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic [4:0]           addr = 5'h00;
   logic [15:0]          wdata = 16'h0000;
   logic                 wr = 1'b0;
   logic                 rd = 1'b0;
   logic [15:0]          rdata, rv, d;
   logic [7:0]           lv;
   logic [3:0]           nib;
   pcei_pkg::pcei_line_t line;
   logic                 pwrdn, col, host_pin, pin_o, pin_oe, clk_stop, sleep, nlp, scr, col_out, pin_pd, irq;
   wire                  pin_lvl = pin_oe ? pin_o : host_pin;
   int                   fails = 0, num_checks = 0, cyc_cnt = 0, seed = 36817, n;

   always #12.5 clk = ~clk;

   pcei_top #(.NLP_CYC(20)) i_pcei_top (
      .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .LINE(line), .IEEE_PWRDN(pwrdn), .COL_RAW(col), .INT_PIN_I(pin_lvl), .INT_PIN_O(pin_o),
      .INT_PIN_OE(pin_oe), .CLK_STOP(clk_stop), .SLEEP(sleep), .NLP_PULSE(nlp), .SCR_BYPASS(scr),
      .FIFO_NIBBLES(nib), .COL_OUT(col_out), .PIN_PWRDN(pin_pd), .IRQ(irq)
   );

   pcei_core_model i_pcei_core_model (.clk(clk), .line(line), .pwrdn(pwrdn), .col(col), .host_pin(host_pin));

   function automatic logic [3:0] nibbles(input logic [1:0] c);
      return (c == 2'h3) ? 4'h8 : 4'h4 + {2'h0, c};
   endfunction : nibbles

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [4:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rv = rdata;
   endtask : rd_reg

   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk16

   task automatic chk1(input logic g, input logic e);
      chk16({15'h0000, g}, {15'h0000, e});
   endtask : chk1

   task automatic drv(input logic p, input logic c, input logic h);
      i_pcei_core_model.drive(lv, p, c, h);
   endtask : drv

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         fails++;
         $display("Error at %0t: run timed out", $time);
         tally_and_finish();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk16({12'h000, nib}, 16'h0005);
      chk1(pin_o, 1'b1);
      chk1(pin_oe, 1'b0);
      rd_reg(5'h11);
      chk16(rv, 16'h0108);
      rd_reg(5'h12);
      chk16(rv, 16'h0000);
      rd_reg(5'h05);
      chk16(rv, 16'h0000);
      $display("test reset done");
      // every depth code first, then random control words
      for (int i = 0; i < 12; i++) begin
         d = (i < 4) ? {6'h00, i[1:0], 8'h08} : 16'($random(seed));
         wr_reg(5'h11, d);
         rd_reg(5'h11);
         chk16(rv, d & 16'hff1f);
         cyc(1);
         chk16({12'h000, nib}, {12'h000, nibbles(d[9:8])});
         chk1(scr, d[11]);
         chk1(clk_stop, 1'b0);
      end
      wr_reg(5'h05, 16'hffff);
      rd_reg(5'h11);
      chk16(rv, d & 16'hff1f);
      $display("test control done");
      lv = 8'h00;
      wr_reg(5'h11, 16'h0103);
      wr_reg(5'h12, 16'hffff);
      rd_reg(5'h12);
      chk16(rv, 16'h00ff);
      lv = 8'h20;
      drv(1'b0, 1'b0, 1'b1);
      cyc(4);
      chk1(pin_lvl, 1'b1);
      rd_reg(5'h12);
      chk16(rv, 16'h20ff);
      cyc(3);
      chk1(pin_lvl, 1'b0);
      for (int i = 7; i >= 0; i--) begin
         if (i != 5) begin
            lv = lv | (8'h01 << i);
            drv(1'b0, 1'b0, 1'b1);
            cyc(4);
            rd_reg(5'h12);
            chk16(rv, {8'h01 << i, 8'hff});
         end
      end
      lv = 8'hdf;
      drv(1'b0, 1'b1, 1'b1);
      wr_reg(5'h11, 16'h0101);
      cyc(3);
      chk1(pin_lvl, 1'b0);
      wr_reg(5'h11, 16'h0105);
      cyc(3);
      chk1(pin_lvl, 1'b1);
      wr_reg(5'h11, 16'h010d);
      cyc(3);
      chk1(pin_lvl, 1'b0);
      wr_reg(5'h11, 16'h010b);
      cyc(3);
      chk1(pin_lvl, 1'b0);
      rd_reg(5'h12);
      chk16(rv, 16'h20ff);
      cyc(3);
      chk1(pin_lvl, 1'b1);
      $display("test events done");
      wr_reg(5'h11, 16'h0108);
      cyc(3);
      chk1(col_out, 1'b0);
      wr_reg(5'h11, 16'h8118);
      cyc(3);
      chk1(col_out, 1'b1);
      chk1(clk_stop, 1'b0);
      lv = 8'hd7;
      drv(1'b1, 1'b1, 1'b0);
      wr_reg(5'h11, 16'h8108);
      cyc(5);
      chk1(col_out, 1'b1);
      chk1(clk_stop, 1'b1);
      chk1(pin_pd, 1'b1);
      drv(1'b0, 1'b0, 1'b1);
      wr_reg(5'h11, 16'h0109);
      cyc(5);
      chk1(pin_pd, 1'b0);
      chk1(pin_oe, 1'b1);
      $display("test pins done");
      lv = 8'h00;
      drv(1'b0, 1'b0, 1'b1);
      wr_reg(5'h1a, 16'h0007);
      wr_reg(5'h11, 16'h6108);
      cyc(1);
      chk1(sleep, 1'b1);
      n = 0;
      repeat (40) begin
         @(posedge clk);
         #1;
         n += int'(nlp);
      end
      chk16(16'(n), 16'h0002);
      rd_reg(5'h1a);
      chk16(rv, 16'h0001);
      wr_reg(5'h1b, 16'h0001);
      cyc(3);
      chk1(irq, 1'b1);
      wr_reg(5'h1a, 16'h0001);
      cyc(3);
      chk1(irq, 1'b0);
      lv = 8'h40;
      drv(1'b0, 1'b0, 1'b1);
      cyc(3);
      chk1(sleep, 1'b0);
      lv = 8'h00;
      drv(1'b0, 1'b0, 1'b1);
      wr_reg(5'h11, 16'h2108);
      cyc(4);
      chk1(sleep, 1'b0);
      wr_reg(5'h11, 16'h4108);
      cyc(4);
      chk1(sleep, 1'b0);
      $display("test sleep done");
      tally_and_finish();
   end
endmodule : tb
